// >>> panel_ctrl.sv
// What this block does
// (R1) Pollution view lights selected connection LED
// (R2) Voltage view: flash lower, steady higher
// (R3) Plus/minus briefly shows setpoint on bar
// (R4) Frequency view lights one of nine
// (R5) Balance view centred, left negative, right positive
// (R6) Fault output high only ready, error free
// (R7) Signal output follows selected mode condition
// (R8) Hardware release is OR of inputs
// (R9) Automatic option releases after boot
// (R10) Keypad option toggles release on on/off
// (R11) External hold blocks local deactivation
// (R12) CAN option sets/clears from command
// (R13) Ethernet option follows fieldbus commands
// (R14) Key lock ignores keys; bus failure unlocks
// (R15) View button advances view, LED steady
// (R16) Pollution view plus/minus steps connection
// (R17) Changes repeat while held, setup inactive
// (R18) Voltage view plus/minus adjusts setpoint
// (R19) Setpoint limited 3.5 to 5.0 kV
// (R20) Setpoint auto-stored, not during setup
// (R21) Permanent reference point blocks setpoint changes
// (R22) Fixed blink divider; out-of-range step ignored
// (R23) Eleven positions; unused positions dark
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module panel_ctrl
  import panel_pkg::*;
#(
  parameter int unsigned BLINK_CYC  = BLINK_CYC_DEF,   // Flash half period
  parameter int unsigned REPEAT_CYC = REPEAT_CYC_DEF,  // Hold repeat period
  parameter int unsigned SHOW_CYC   = SHOW_CYC_DEF     // Setpoint show time
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Keypad pins, high while pressed
  input  wire logic        key_plus,
  input  wire logic        key_minus,
  input  wire logic        key_view,
  input  wire logic        key_onoff,
  // Hardware release pins
  input  wire logic        release1,
  input  wire logic        release2,
  // Front panel and plant outputs
  output logic [10:0]      bar_led,
  output logic [3:0]       view_led,
  output logic [3:0]       conn_led,
  output logic             hw_release,
  output logic             sw_release,
  output logic             fault_out,
  output logic             signal_out
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (BLINK_CYC < 1 || REPEAT_CYC < 1 || SHOW_CYC < 1) begin : g_bad_time
    $error("panel_ctrl: time counts must be at least one cycle");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]        sync1;      // First stage, read by sync2 only
    logic [5:0]        sync2;      // Synchronised pins
    logic [3:0]        key_prev;   // Key levels of the last cycle
    logic [CTRL_W-1:0] ctrl;       // Control and status inputs
    logic              key_lock;   // Keypad disabled
    logic [5:0]        meas;       // Measured voltage
    logic [31:0]       poll;       // Four pollution percentages
    logic [7:0]        fb;         // Frequency index and balance
    logic [5:0]        setpt;      // Stored voltage setpoint
    view_t             view;       // Active bar view
    logic [1:0]        conn;       // Displayed connection
    logic              sw_rel;     // Software release
    logic [31:0]       rep_cnt;    // Auto-repeat timer
    logic [31:0]       show_cnt;   // Setpoint show timer
    logic [31:0]       blink_cnt;  // Flash divider
    logic              blink;      // Flash phase
    logic [10:0]       bar;        // Registered bar pattern
    logic              hw_rel;     // Registered hardware release
    logic              fault;      // Registered fault output
    logic              sig;        // Registered signal output
  } state_t;

  state_t s_q;  // Current state
  state_t s_d;  // Next state

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic wr_en;    // Write access phase
  logic hit;      // Address maps to a register
  assign wr_en = psel && penable && pwrite;
  assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_MEAS) ||
               (paddr == ADDR_POLL) || (paddr == ADDR_FB) ||
               (paddr == ADDR_CMD) || (paddr == ADDR_SETPT) ||
               (paddr == ADDR_STATUS);
  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Read mux from registered state only
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel) begin
      case (paddr)
        ADDR_CTRL: begin
          prdata[CTRL_W-1:0]    = s_q.ctrl;
          prdata[CTRL_KEYLOCK]  = s_q.key_lock;
        end
        ADDR_MEAS:   prdata[5:0]  = s_q.meas;
        ADDR_POLL:   prdata       = s_q.poll;
        ADDR_FB:     prdata[7:0]  = s_q.fb;
        ADDR_SETPT:  prdata[5:0]  = s_q.setpt;
        ADDR_STATUS: prdata[20:0] = {s_q.bar, s_q.conn, s_q.view,
                                     s_q.sig, s_q.fault, s_q.hw_rel,
                                     s_q.sw_rel};
        default:     prdata = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Bar patterns for each view
  // --------------------------------------------------------------------------
  logic [5:0]  volt_shown;   // Measured value or setpoint
  logic [7:0]  poll_sel;     // Percentage of displayed connection
  logic [10:0] pat_kv;
  logic [10:0] pat_hz;
  logic [10:0] pat_poll;
  logic [10:0] pat_bal;
  int          volt_ofs;     // Steps above 3.1 kV
  int          bal_v;        // Signed balance offset

  assign volt_shown = (s_q.show_cnt != 32'h0) ? s_q.setpt : s_q.meas;  // [R3]
  assign poll_sel   = s_q.poll[8*s_q.conn +: 8];
  assign volt_ofs   = int'(volt_shown) - int'(VOLT_BAR_BASE);
  assign bal_v      = int'($signed(s_q.fb[7:4]));

  for (genvar i = 0; i < BAR_N; i++) begin : g_bar
    // Two values per position: flash for the lower, steady for the higher
    assign pat_kv[i] = (volt_shown >= VOLT_BAR_BASE) &&
                       (volt_shown <= VOLT_BAR_TOP) &&
                       (volt_ofs / 2 == i) &&
                       ((volt_ofs % 2 == 1) || s_q.blink);  // [R2] [R23]
    assign pat_hz[i] = (int'(s_q.fb[3:0]) == i) && (i < FREQ_STEPS);  // [R4]
    // Bar graph of percent; LED n lights once 11*p reaches 100*(n+1)
    assign pat_poll[i] = (int'(poll_sel) * BAR_N >= (i + 1) * POLL_FULL);
    // Centre is zero, lit run extends toward the offset side
    assign pat_bal[i] = (i == BAR_CENTRE) ||  // [R5]
                        ((i < BAR_CENTRE) && (i >= BAR_CENTRE + bal_v)) ||
                        ((i > BAR_CENTRE) && (i <= BAR_CENTRE + bal_v));
  end

  // --------------------------------------------------------------------------
  // Keypad events
  // --------------------------------------------------------------------------
  logic [3:0] key_lvl;    // plus, minus, view, onoff
  logic       any_held;   // A repeating key is down
  logic       rep_tick;   // Repeat interval elapsed
  logic       keys_ok;    // Keypad may act
  logic       ev_plus;
  logic       ev_minus;
  logic       ev_view;
  logic       ev_onoff;

  // Keys sit in the upper four synchroniser bits, release pins below
  assign key_lvl  = s_q.sync2[5:2];
  assign any_held = |key_lvl[3:1];
  assign rep_tick = any_held && (s_q.rep_cnt == 32'h1);
  assign keys_ok  = !s_q.key_lock && !s_q.ctrl[CTRL_SETUP];  // [R14] [R17]
  // Press edge, or repeat while held
  assign ev_plus  = keys_ok && key_lvl[3] &&
                    (!s_q.key_prev[3] || rep_tick);  // [R17]
  assign ev_minus = keys_ok && key_lvl[2] &&
                    (!s_q.key_prev[2] || rep_tick);
  assign ev_view  = keys_ok && key_lvl[1] &&
                    (!s_q.key_prev[1] || rep_tick);
  // On/off never repeats, or a long press would flip the release twice
  assign ev_onoff = !s_q.key_lock && key_lvl[0] && !s_q.key_prev[0];

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [2:0] opt;
    logic [4:0] cmd;
    s_d = s_q;
    opt = s_q.ctrl[CTRL_OPT_LO +: 3];
    cmd = (wr_en && paddr == ADDR_CMD) ? pwdata[4:0] : 5'h00;

    // Pin synchronisers
    s_d.sync1    = {key_plus, key_minus, key_view, key_onoff,
                    release2, release1};
    s_d.sync2    = s_q.sync1;
    s_d.key_prev = key_lvl;

    // Register writes
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL: begin
          s_d.ctrl     = pwdata[CTRL_W-1:0];
          s_d.key_lock = pwdata[CTRL_KEYLOCK];
        end
        ADDR_MEAS: s_d.meas = pwdata[5:0];
        ADDR_POLL: s_d.poll = pwdata;
        ADDR_FB:   s_d.fb   = pwdata[7:0];
        default:   s_d.ctrl = s_q.ctrl;
      endcase
    end
    // Bus failure unlocks and wins over a lock written at once
    if (cmd[CMD_BUS_FAIL]) begin
      s_d.key_lock = 1'b0;  // [R14]
    end

    // Fixed flash divider
    if (s_q.blink_cnt >= BLINK_CYC - 1) begin
      s_d.blink_cnt = 32'h0;
      s_d.blink     = !s_q.blink;  // [R22]
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 32'h1;
    end

    // Repeat timer restarts on each press and each repeat
    if (!any_held) begin
      s_d.rep_cnt = 32'h0;
    end else if (s_q.rep_cnt <= 32'h1) begin
      s_d.rep_cnt = REPEAT_CYC;
    end else begin
      s_d.rep_cnt = s_q.rep_cnt - 32'h1;
    end

    // Setpoint show timer
    if (s_q.show_cnt != 32'h0) begin
      s_d.show_cnt = s_q.show_cnt - 32'h1;
    end

    // View advances in kV, Hz, pollution, balance order
    if (ev_view) begin
      case (s_q.view)
        VIEW_KV:    s_d.view = VIEW_HZ;
        VIEW_HZ:    s_d.view = VIEW_BRUSH;
        VIEW_BRUSH: s_d.view = VIEW_BAL;
        VIEW_BAL:   s_d.view = VIEW_KV;
        default:    s_d.view = VIEW_KV;
      endcase  // [R15]
      s_d.show_cnt = 32'h0;
    end else if (s_q.view == VIEW_BRUSH) begin
      // Plus and minus pick the connection here
      if (ev_plus) begin
        s_d.conn = s_q.conn + 2'h1;  // [R16]
      end else if (ev_minus) begin
        s_d.conn = s_q.conn - 2'h1;  // [R16]
      end
    end else if (s_q.view == VIEW_KV && (ev_plus || ev_minus)) begin
      // Show the setpoint at once, even if the change is refused
      s_d.show_cnt = SHOW_CYC;  // [R3] [R18]
      if (!s_q.ctrl[CTRL_REFPERM]) begin  // [R21]
        // A step past either limit leaves the setpoint alone
        if (ev_plus && s_q.setpt < SETPT_MAX) begin
          s_d.setpt = s_q.setpt + 6'h01;  // [R18] [R19] [R20] [R22]
        end else if (ev_minus && !ev_plus && s_q.setpt > SETPT_MIN) begin
          s_d.setpt = s_q.setpt - 6'h01;  // [R18] [R19] [R20] [R22]
        end
      end
    end

    // Software release by option
    case (opt)
      OPT_AUTO: s_d.sw_rel = s_q.ctrl[CTRL_BOOTED];  // [R9]
      OPT_KEY: begin
        if (ev_onoff) begin
          // External hold keeps a set release from being cleared here
          if (!s_q.sw_rel) begin
            s_d.sw_rel = 1'b1;  // [R10]
          end else if (!s_q.ctrl[CTRL_EXT_HOLD]) begin
            s_d.sw_rel = 1'b0;  // [R10] [R11]
          end
        end
      end
      OPT_CAN: begin
        if (cmd[CMD_CAN_SET]) begin
          s_d.sw_rel = 1'b1;  // [R12]
        end else if (cmd[CMD_CAN_CLR]) begin
          s_d.sw_rel = 1'b0;  // [R12]
        end
      end
      OPT_ETH: begin
        if (cmd[CMD_ETH_SET]) begin
          s_d.sw_rel = 1'b1;  // [R13]
        end else if (cmd[CMD_ETH_CLR]) begin
          s_d.sw_rel = 1'b0;  // [R13]
        end
      end
      default: s_d.sw_rel = 1'b0;
    endcase

    // Plant outputs
    s_d.hw_rel = s_q.sync2[0] || s_q.sync2[1];  // [R8]
    s_d.fault  = s_q.ctrl[CTRL_READY] && !s_q.ctrl[CTRL_ERROR];  // [R6]
    case (s_q.ctrl[CTRL_MODE_LO +: 2])
      MODE_HV:   s_d.sig = s_q.ctrl[CTRL_HV_ON];  // [R7]
      MODE_WARN: s_d.sig = s_q.ctrl[CTRL_WARN];  // [R7]
      MODE_POLL: s_d.sig = s_q.ctrl[CTRL_POLLUTED];  // [R7]
      default:   s_d.sig = 1'b0;
    endcase

    // Bar pattern of the active view
    case (s_q.view)
      VIEW_KV:    s_d.bar = pat_kv;
      VIEW_HZ:    s_d.bar = pat_hz;
      VIEW_BRUSH: s_d.bar = pat_poll;
      VIEW_BAL:   s_d.bar = pat_bal;
      default:    s_d.bar = 11'h000;  // [R23]
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.setpt <= SETPT_RST;
      s_q.view  <= VIEW_KV;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops, conn_led decoded from view and conn
  assign bar_led    = s_q.bar;
  assign view_led   = s_q.view;  // [R15]
  assign conn_led   = (s_q.view == VIEW_BRUSH) ?
                      (4'h1 << s_q.conn) : 4'h0;  // [R1]
  assign hw_release = s_q.hw_rel;
  assign sw_release = s_q.sw_rel;
  assign fault_out  = s_q.fault;
  assign signal_out = s_q.sig;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hw_release_or: assert property ( // [R8]
    ##3 (hw_release == ($past(release1, 3) || $past(release2, 3))))
    else $error("hardware release is not the OR of the inputs");

  a_fault_level: assert property ( // [R6]
    ##1 (fault_out == ($past(s_q.ctrl[CTRL_READY]) &&
                       !$past(s_q.ctrl[CTRL_ERROR]))))
    else $error("fault output does not follow ready and error");

  a_setpt_range: assert property ( // [R19]
    (s_q.setpt >= SETPT_MIN) && (s_q.setpt <= SETPT_MAX))
    else $error("setpoint left its range");

  a_setpt_refperm: assert property ( // [R21]
    s_q.ctrl[CTRL_REFPERM] |=> $stable(s_q.setpt))
    else $error("setpoint changed under permanent reference");

  a_keylock_view: assert property ( // [R14]
    s_q.key_lock |=> $stable(s_q.view) && $stable(s_q.conn))
    else $error("view changed while keypad locked");

  a_busfail_unlock: assert property ( // [R14]
    (wr_en && paddr == ADDR_CMD && pwdata[CMD_BUS_FAIL]) |=> !s_q.key_lock)
    else $error("bus failure did not release key lock");

  a_conn_led_sel: assert property ( // [R1]
    (s_q.view == VIEW_BRUSH) |-> $onehot(conn_led))
    else $error("connection LED missing in pollution view");

  a_auto_release: assert property ( // [R9]
    (s_q.ctrl[CTRL_OPT_LO +: 3] == OPT_AUTO && s_q.ctrl[CTRL_BOOTED])
      |=> sw_release)
    else $error("automatic release not set after boot");

  a_freq_bar: assert property ( // [R4]
    (s_q.view == VIEW_HZ && $stable(s_q.view) && $stable(s_q.fb) &&
     s_q.fb[3:0] < 4'h9) |-> (bar_led == (11'h001 << s_q.fb[3:0])))
    else $error("frequency bar does not match index");

  a_show_setpt: assert property ( // [R3]
    (s_q.view == VIEW_KV && ev_plus && !ev_view) |=> (s_q.show_cnt != 32'h0))
    else $error("setpoint not shown after key press");

  a_ext_hold: assert property ( // [R11]
    (s_q.ctrl[CTRL_OPT_LO +: 3] == OPT_KEY && s_q.ctrl[CTRL_EXT_HOLD] &&
     s_q.sw_rel) |=> sw_release)
    else $error("release cleared locally under external hold");

  c_view_step: cover property (ev_view ##1 (s_q.view == VIEW_HZ));
  c_setpt_up: cover property (ev_plus && s_q.view == VIEW_KV ##1
                              $changed(s_q.setpt));
  c_key_release: cover property (ev_onoff ##1 sw_release);
  c_show_end: cover property ((s_q.show_cnt == 32'h1) ##1
                              (s_q.show_cnt == 32'h0));

endmodule
`default_nettype wire

// >>> panel_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the front panel block
// ----------------------------------------------------------------------------
package panel_pkg;

  // Clock and time figures
  localparam int unsigned CLK_FREQ_HZ   = 50_000_000;  // pclk rate
  localparam int unsigned BLINK_HALF_MS = 250;         // Half period of flash
  localparam int unsigned REPEAT_MS     = 300;         // Auto-repeat interval
  localparam int unsigned SHOW_MS       = 2000;        // Setpoint show time
  localparam int unsigned CYC_PER_MS    = CLK_FREQ_HZ / 1000;
  localparam int unsigned BLINK_CYC_DEF = BLINK_HALF_MS * CYC_PER_MS;
  localparam int unsigned REPEAT_CYC_DEF = REPEAT_MS * CYC_PER_MS;
  localparam int unsigned SHOW_CYC_DEF  = SHOW_MS * CYC_PER_MS;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Options and status inputs
  localparam logic [7:0] ADDR_MEAS   = 8'h04;  // Measured voltage
  localparam logic [7:0] ADDR_POLL   = 8'h08;  // Pollution per connection
  localparam logic [7:0] ADDR_FB     = 8'h0C;  // Frequency and balance
  localparam logic [7:0] ADDR_CMD    = 8'h10;  // Fieldbus command strobes
  localparam logic [7:0] ADDR_SETPT  = 8'h14;  // Voltage setpoint
  localparam logic [7:0] ADDR_STATUS = 8'h18;  // Block state

  // Control register fields
  localparam int CTRL_OPT_LO   = 0;   // Software release option [2:0]
  localparam int CTRL_MODE_LO  = 3;   // Signal output mode [4:3]
  localparam int CTRL_KEYLOCK  = 5;
  localparam int CTRL_REFPERM  = 6;
  localparam int CTRL_SETUP    = 7;
  localparam int CTRL_BOOTED   = 8;
  localparam int CTRL_READY    = 9;
  localparam int CTRL_ERROR    = 10;
  localparam int CTRL_HV_ON    = 11;
  localparam int CTRL_WARN     = 12;
  localparam int CTRL_POLLUTED = 13;
  localparam int CTRL_EXT_HOLD = 14;
  localparam int CTRL_W        = 15;

  // Command register strobes
  localparam int CMD_CAN_SET  = 0;
  localparam int CMD_CAN_CLR  = 1;
  localparam int CMD_ETH_SET  = 2;
  localparam int CMD_ETH_CLR  = 3;
  localparam int CMD_BUS_FAIL = 4;

  // Software release options and signal modes
  localparam logic [2:0] OPT_OFF  = 3'h0;
  localparam logic [2:0] OPT_AUTO = 3'h1;
  localparam logic [2:0] OPT_KEY  = 3'h2;
  localparam logic [2:0] OPT_CAN  = 3'h3;
  localparam logic [2:0] OPT_ETH  = 3'h4;
  localparam logic [1:0] MODE_HV   = 2'h0;
  localparam logic [1:0] MODE_WARN = 2'h1;
  localparam logic [1:0] MODE_POLL = 2'h2;

  // Value ranges, voltages in units of 100 V
  localparam logic [5:0] VOLT_BAR_BASE = 6'h1F;  // 3.1 kV, first flash
  localparam logic [5:0] VOLT_BAR_TOP  = 6'h32;  // 5.0 kV, last steady
  localparam logic [5:0] SETPT_MIN     = 6'h23;  // 3.5 kV
  localparam logic [5:0] SETPT_MAX     = 6'h32;  // 5.0 kV
  localparam logic [5:0] SETPT_RST     = 6'h2D;  // 4.5 kV after reset
  localparam int         BAR_N         = 11;
  localparam int         BAR_CENTRE    = 5;
  localparam int         FREQ_STEPS    = 9;
  localparam int         POLL_FULL     = 100;

  // Bar views, one-hot
  typedef enum logic [3:0] {
    VIEW_KV    = 4'h1,
    VIEW_HZ    = 4'h2,
    VIEW_BRUSH = 4'h4,
    VIEW_BAL   = 4'h8
  } view_t;

endpackage

// >>> operator_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Operator at the keypad and plant release
// ----------------------------------------
module operator_model (
  // Clock
  input  wire logic       pclk,
  // Keys: 0 plus, 1 minus, 2 view, 3 on/off
  output var logic [3:0]  keys,
  // Hardware release pins
  output var logic [1:0]  rel
);
  initial begin
    keys = 4'h0;
    rel  = 2'h0;
  end

  // Hold a key for n cycles, then let it rest well past the sync delay
  task automatic press(input int k, input int n);
    @(posedge pclk);
    keys[k] <= 1'b1;
    repeat (n) @(posedge pclk);
    keys[k] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  // Set both hardware release pins just after a clock edge
  task automatic set_release(input logic [1:0] v);
    @(posedge pclk);
    rel <= v;
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import panel_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        pclk = 0, presetn = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic [3:0]  keys, view_led, conn_led;
  logic [1:0]  rel;
  logic [10:0] bar_led;
  logic        hw_release, sw_release, fault_out, signal_out;
  int          num_errors = 0, checked = 0, cyc = 0;

  always #10 pclk = ~pclk;

  operator_model op (.pclk(pclk), .keys(keys), .rel(rel));

  // Short counts keep the run brief; expectations follow them
  panel_ctrl #(.BLINK_CYC(4), .REPEAT_CYC(20), .SHOW_CYC(50)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_plus(keys[0]),
    .key_minus(keys[1]), .key_view(keys[2]), .key_onoff(keys[3]),
    .release1(rel[0]), .release2(rel[1]), .bar_led(bar_led),
    .view_led(view_led), .conn_led(conn_led), .hw_release(hw_release),
    .sw_release(sw_release), .fault_out(fault_out),
    .signal_out(signal_out));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    repeat (2) @(posedge pclk);
  endtask

  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction

  // Hang guard, well above the under one thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    check("view", view_led, 4'h1);
    apb(0, ADDR_SETPT, 0); check("setpt", rd, 32'h2D);
    apb(0, 8'h40, 0); check("unmapped rd", rd, 0); // Unmapped
    check("slverr", err, 1); // Unmapped
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      op.set_release(2'(i));
      repeat (5) @(posedge pclk);
      check("hw_rel", hw_release, i != 0);
    end
    apb(1, ADDR_CTRL, b(CTRL_READY)); check("fault", fault_out, 1);
    apb(1, ADDR_CTRL, b(CTRL_READY) | b(CTRL_ERROR));
    check("fault", fault_out, 0);
    for (int m = 0; m < 3; m++) begin
      apb(1, ADDR_CTRL, (m << 3) | b(CTRL_HV_ON + m));
      check("sig", signal_out, 1);
      apb(1, ADDR_CTRL, (m << 3) | (32'h3800 ^ b(CTRL_HV_ON + m)));
      check("sig", signal_out, 0);
    end
    $display("test outputs done");
    apb(1, ADDR_CTRL, OPT_AUTO | b(CTRL_BOOTED));
    check("sw auto", sw_release, 1);
    for (int k = 0; k < 2; k++) begin
      apb(1, ADDR_CTRL, 32'(OPT_CAN + k));
      // Clear, set, clear: every step but the first Ethernet clear changes the release
      for (int n = 0; n < 3; n++) begin
        apb(1, ADDR_CMD, b(2 * k + (n + 1) % 2));
        check("sw fieldbus", sw_release, n % 2);
      end
    end
    apb(1, ADDR_CTRL, OPT_KEY);
    op.press(3, 3); check("sw key", sw_release, 1);
    op.press(3, 3); check("sw key", sw_release, 0);
    op.press(3, 3);
    apb(1, ADDR_CTRL, OPT_KEY | b(CTRL_EXT_HOLD));
    op.press(3, 3); check("sw hold", sw_release, 1);
    $display("test release done");
    // Measured value at the top of the bar, setpoint shown on a press
    apb(1, ADDR_MEAS, 32'h32);
    check("bar meas", bar_led[10:9], 2'b01);
    op.press(0, 3);
    check("bar setpt", {bar_led[9], bar_led[7]}, 2'b01);
    apb(0, ADDR_SETPT, 0); check("setpt", rd, 32'h2E);
    repeat (60) @(posedge pclk);
    check("bar back", bar_led[9], 1);
    op.press(0, 30);
    apb(0, ADDR_SETPT, 0); check("repeat", rd, 32'h30);
    repeat (4) op.press(0, 3);
    apb(0, ADDR_SETPT, 0); check("max", rd, 32'h32);
    repeat (20) op.press(1, 3);
    apb(0, ADDR_SETPT, 0); check("min", rd, 32'h23);
    for (int i = 0; i < 3; i++) begin
      apb(1, ADDR_CTRL, b(CTRL_KEYLOCK + i));
      op.press(0, 3);
      apb(0, ADDR_SETPT, 0); check("blocked", rd, 32'h23);
    end
    apb(1, ADDR_CTRL, b(CTRL_KEYLOCK));
    apb(1, ADDR_CMD, b(CMD_BUS_FAIL));
    op.press(0, 3);
    apb(0, ADDR_SETPT, 0); check("unlock", rd, 32'h24);
    $display("test setpoint done");
    op.press(2, 3); check("view hz", view_led, 4'h2);
    apb(1, ADDR_FB, 32'h3);
    check("bar hz", bar_led, 11'h008);
    op.press(2, 3); check("conn", {view_led, conn_led}, 8'h41);
    op.press(0, 3); check("conn", conn_led, 4'h2);
    apb(1, ADDR_POLL, 32'h0000_3200);
    check("bar poll", bar_led, 11'h01F);
    op.press(2, 3); apb(1, ADDR_FB, 32'h0);
    check("bar bal", bar_led, 11'h020);
    apb(1, ADDR_FB, 32'h20);
    check("bar bal", {bar_led[7], bar_led[3]}, 2'b10);
    apb(1, ADDR_FB, 32'hE0);
    check("bar bal", bar_led, 11'h038);
    op.press(2, 3); check("wrap", view_led, 4'h1);
    $display("test views done");
    give_verdict();
  end
endmodule
`default_nettype wire
